// ### mrc_defs.vh
/*
  constants for the mode and ring control register pair: offsets,
  field positions, reset values and pipeline timing.
  assumes inclusion by bare name from the design files.
*/
`ifndef MRC_DEFS_VH
`define MRC_DEFS_VH

// ****************************************
// register addresses on data page 0
// ****************************************
`define MRC_ADDR_W 7
`define MRC_RING_CTRL_ADDR 7'h1e
`define MRC_MODE_ADDR 7'h07

// ****************************************
// ring control fields
// ****************************************
`define MRC_R2_EN_BIT 7
`define MRC_R2_SEL_HI 6
`define MRC_R2_SEL_LO 4
`define MRC_R1_EN_BIT 3
`define MRC_R1_SEL_HI 2
`define MRC_R1_SEL_LO 0
`define MRC_RING_RESV_HI 15
`define MRC_RING_RESV_LO 8

// ****************************************
// mode register fields
// ****************************************
`define MRC_VPAGE_HI 15
`define MRC_VPAGE_LO 11
`define MRC_MODE_ZERO_HI 10
`define MRC_MODE_ZERO_LO 8
`define MRC_ADDRESS_VISIBILITY_BIT 7

// ****************************************
// reset values and timing
// ****************************************
`define MRC_RING_RESET 16'h0000
`define MRC_MODE_RESET 16'h0000
`define MRC_HOLD_SLOTS 2

`endif

// ### mrc_shadow.v
/*
  one-entry shadow store for the mode register bits kept by this block.
  assumes save and restore come from the trap and return logic in the
  core, never both in one cycle; save wins if they do.
*/
`timescale 1ns/100ps
`default_nettype none

module mrc_shadow #(
  parameter WIDTH = 6
) (
  input wire clk,
  input wire rst_n,
  input wire save,
  input wire [WIDTH-1:0] save_data,
  output reg [WIDTH-1:0] held_data
);

  // ****************************************
  // storage
  // ****************************************
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      held_data <= {WIDTH{1'b0}};
    else if (save)
      held_data <= save_data;
  end

endmodule

`default_nettype wire

// ### mrc_ctrl_regs.v
/*
  ring buffer control and processor mode registers of the cpu core,
  mapped in data page 0, written by the math and logic units in execute,
  with interrupt shadow of the mode register and address visibility.
  assumes one clock, all inputs synchronous, one write per cycle.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mrc_defs.vh"

module mrc_ctrl_regs #(
  parameter PA_W = 16
) (
  input wire CORE_CLK,
  input wire NRST,
  input wire [`MRC_ADDR_W-1:0] EXE_ADDR,
  input wire EXE_WR,
  input wire EXE_RD,
  input wire [15:0] EXE_WDATA,
  input wire PIPE_ADV,
  input wire TRAP_TAKEN,
  input wire INT_RET,
  input wire [PA_W-1:0] PROG_ADDR,
  input wire PROG_ADDR_EXT,
  output reg [15:0] EXE_RDATA,
  output reg RING1_ENABLE,
  output reg [2:0] RING1_POINTER_SELECT,
  output reg RING2_ENABLE,
  output reg [2:0] RING2_POINTER_SELECT,
  output reg [4:0] VECTOR_PAGE_SELECT,
  output reg ADDRESS_VISIBILITY,
  output reg [PA_W-1:0] EXT_ADDR
);

  localparam S_IDLE = 2'd0;
  localparam S_HOLD = 2'd1;

  // ****************************************
  // architectural state
  // ****************************************
  reg [7:0] ring_reg;
  reg [7:0] ring_next;
  reg [4:0] vpage_reg;
  reg [4:0] vpage_next;
  reg address_visibility_reg;
  reg address_visibility_next;
  reg [1:0] state_reg;
  reg [1:0] hold_cnt_reg;
  wire [5:0] shadow_q;
  wire wr_ring;
  wire wr_mode;

  function hit;
    input [`MRC_ADDR_W-1:0] a;
    input [`MRC_ADDR_W-1:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  assign wr_ring = EXE_WR & hit(EXE_ADDR, `MRC_RING_CTRL_ADDR);
  assign wr_mode = EXE_WR & hit(EXE_ADDR, `MRC_MODE_ADDR);

  // ****************************************
  // shadow of the mode bits
  // ****************************************
  mrc_shadow #(
    .WIDTH(6)
  ) u_shadow (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .save(TRAP_TAKEN),
    .save_data({vpage_reg, address_visibility_reg}),
    .held_data(shadow_q)
  );

  // ****************************************
  // next values
  // ****************************************
  always @*
  begin
    ring_next = ring_reg;
    vpage_next = vpage_reg;
    address_visibility_next = address_visibility_reg;
    if (wr_ring)
      ring_next = EXE_WDATA[7:0];
    if (TRAP_TAKEN)
    begin
      vpage_next = vpage_reg;
      address_visibility_next = address_visibility_reg;
    end
    else if (INT_RET)
    begin
      vpage_next = shadow_q[5:1];
      address_visibility_next = shadow_q[0];
    end
    else if (wr_mode)
    begin
      vpage_next = EXE_WDATA[`MRC_VPAGE_HI:`MRC_VPAGE_LO];
      address_visibility_next = EXE_WDATA[`MRC_ADDRESS_VISIBILITY_BIT];
    end
  end

  // ****************************************
  // registers; pointer fields reset too, harmless
  // ****************************************
  always @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      ring_reg <= 8'h00;
      vpage_reg <= 5'h00;
      address_visibility_reg <= 1'b0;
    end
    else
    begin
      ring_reg <= ring_next;
      vpage_reg <= vpage_next;
      address_visibility_reg <= address_visibility_next;
    end
  end

  // ****************************************
  // two-slot delay before outputs follow
  // ****************************************
  // config outputs lag so the next two issued slots keep old setting
  always @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      state_reg <= S_IDLE;
      hold_cnt_reg <= 2'h0;
      RING1_ENABLE <= 1'b0;
      RING1_POINTER_SELECT <= 3'h0;
      RING2_ENABLE <= 1'b0;
      RING2_POINTER_SELECT <= 3'h0;
      VECTOR_PAGE_SELECT <= 5'h00;
      ADDRESS_VISIBILITY <= 1'b0;
    end
    else
    begin
      case (state_reg)
        S_IDLE:
        begin
          if (wr_ring | wr_mode | INT_RET)
          begin
            state_reg <= S_HOLD;
            hold_cnt_reg <= 2'h0;
          end
        end
        S_HOLD:
        begin
          if (wr_ring | wr_mode | INT_RET)
            hold_cnt_reg <= 2'h0;
          else if (PIPE_ADV)
          begin
            if (hold_cnt_reg == `MRC_HOLD_SLOTS - 1)
            begin
              state_reg <= S_IDLE;
              RING1_ENABLE <= ring_reg[`MRC_R1_EN_BIT];
              RING1_POINTER_SELECT <=
                ring_reg[`MRC_R1_SEL_HI:`MRC_R1_SEL_LO];
              RING2_ENABLE <= ring_reg[`MRC_R2_EN_BIT];
              RING2_POINTER_SELECT <=
                ring_reg[`MRC_R2_SEL_HI:`MRC_R2_SEL_LO];
              VECTOR_PAGE_SELECT <= vpage_reg;
              ADDRESS_VISIBILITY <= address_visibility_reg;
            end
            else
              hold_cnt_reg <= hold_cnt_reg + 2'h1;
          end
        end
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      EXE_RDATA <= 16'h0000;
    else if (EXE_RD && hit(EXE_ADDR, `MRC_RING_CTRL_ADDR))
      EXE_RDATA <= {8'h00, ring_reg};
    else if (EXE_RD && hit(EXE_ADDR, `MRC_MODE_ADDR))
      EXE_RDATA <= {vpage_reg, 3'h0, address_visibility_reg, 7'h00};
    else
      EXE_RDATA <= 16'h0000;
  end

  // ****************************************
  // external address pins
  // ****************************************
  // low-order mode bits live elsewhere, so they read back as 0 here
  always @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      EXT_ADDR <= {PA_W{1'b0}};
    else if (!ADDRESS_VISIBILITY || PROG_ADDR_EXT)
      EXT_ADDR <= PROG_ADDR;
    // else hold last external address
  end

endmodule

`default_nettype wire

// ### mrc_cpu_model.sv
/* cpu pipeline stand-in: slot advance and fetch address.
   assumes the bench clock; slow mode stalls slots at random */
`timescale 1ns/100ps
`default_nettype none
module mrc_cpu_model (
  input wire logic clk,
  input wire logic slow,
  output logic adv,
  output logic [15:0] pa,
  output logic pa_ext
);
  initial
  begin
    adv = 1'b0;
    pa = 16'h0000;
    pa_ext = 1'b0;
  end
  // new values just after the falling edge, never near sampling
  always @(negedge clk)
  begin
    adv <= slow ? 1'($urandom % 3 == 0) : 1'b1;
    pa <= 16'($urandom);
    pa_ext <= 1'($urandom % 4 == 0);
  end
endmodule
`default_nettype wire

// ### mrc_ctrl_regs_chk.sv
/* port checker for the mode and ring control registers.
   assumes bind onto mrc_ctrl_regs, one clock */
`timescale 1ns/100ps
`default_nettype none
module mrc_chk #(parameter PA_W = 16) (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic [6:0] EXE_ADDR,
  input wire logic EXE_WR,
  input wire logic EXE_RD,
  input wire logic PIPE_ADV,
  input wire logic INT_RET,
  input wire logic [PA_W-1:0] PROG_ADDR,
  input wire logic PROG_ADDR_EXT,
  input wire logic [15:0] EXE_RDATA,
  input wire logic RING1_ENABLE,
  input wire logic [2:0] RING1_POINTER_SELECT,
  input wire logic RING2_ENABLE,
  input wire logic [2:0] RING2_POINTER_SELECT,
  input wire logic [4:0] VECTOR_PAGE_SELECT,
  input wire logic ADDRESS_VISIBILITY,
  input wire logic [PA_W-1:0] EXT_ADDR
);
  wire [7:0] ring = {RING2_ENABLE, RING2_POINTER_SELECT,
    RING1_ENABLE, RING1_POINTER_SELECT};
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  property p_ring_rd;
    EXE_RD && EXE_ADDR == 7'h1e |=> EXE_RDATA[15:8] == 8'h00;
  endproperty
  a_ring_rd: assert property (p_ring_rd)
    else $error("ring read upper byte set");
  property p_mode_rd;
    EXE_RD && EXE_ADDR == 7'h07 |=> EXE_RDATA[10:8] == 3'h0;
  endproperty
  a_mode_rd: assert property (p_mode_rd)
    else $error("mode read bits 10-8 set");
  property p_unmap;
    EXE_RD && EXE_ADDR != 7'h1e && EXE_ADDR != 7'h07 |=> EXE_RDATA == 0;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  property p_idle;
    !EXE_RD |=> EXE_RDATA == 16'h0000;
  endproperty
  a_idle: assert property (p_idle)
    else $error("read data without read");
  property p_vis;
    !ADDRESS_VISIBILITY || PROG_ADDR_EXT |=> EXT_ADDR == $past(PROG_ADDR);
  endproperty
  a_vis: assert property (p_vis)
    else $error("pins do not follow address");
  property p_hold;
    ADDRESS_VISIBILITY && !PROG_ADDR_EXT |=> $stable(EXT_ADDR);
  endproperty
  a_hold: assert property (p_hold)
    else $error("pins moved while hidden");
  property p_noadv;
    !PIPE_ADV |=> $stable(ring);
  endproperty
  a_noadv: assert property (p_noadv)
    else $error("ring config moved without slot");
  property p_wr;
    EXE_WR && (EXE_ADDR == 7'h1e || EXE_ADDR == 7'h07) |=> $stable(ring);
  endproperty
  a_wr: assert property (p_wr)
    else $error("ring config moved right after write");
  property p_page;
    !PIPE_ADV && !INT_RET |=> $stable(VECTOR_PAGE_SELECT);
  endproperty
  a_page: assert property (p_page)
    else $error("vector page moved without slot");
  c_wr: cover property (EXE_WR && EXE_ADDR == 7'h1e);
  c_ret: cover property (INT_RET);
  c_hide: cover property (ADDRESS_VISIBILITY && !PROG_ADDR_EXT);
endmodule
bind mrc_ctrl_regs mrc_chk #(.PA_W(PA_W)) i_chk (.*);
`default_nettype wire

// ### test_dsp_mode_and_ring_control_regs.sv
/* self-checking bench for mrc_ctrl_regs against an integer model.
   assumes mrc_cpu_model drives slots and fetch addresses */
`timescale 1ns/100ps
`default_nettype none
module test_dsp_mode_and_ring_control_regs;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic slow = 1'b0;
  logic [3:0] f = 4'h0;
  logic [6:0] addr = 7'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata, xa, pa, d;
  logic adv, pa_ext, r1e, r2e, address_visibility;
  logic [2:0] r1s, r2s;
  logic [4:0] vp;
  int miscompares = 0, n_checks = 0, ring = 0, mode = 0, sh = 0;
  int cfg = 0, cfgm = 0, cnt = 0, exp_rd = 0, k;
  logic [6:0] ra;
  always #10 clk = ~clk;
  mrc_cpu_model i_cpu (.clk(clk), .slow(slow), .adv(adv), .pa(pa),
    .pa_ext(pa_ext));
  mrc_ctrl_regs i_dut (.CORE_CLK(clk), .NRST(nrst), .EXE_ADDR(addr),
    .EXE_WR(f[3]), .EXE_RD(f[2]), .EXE_WDATA(wdata), .PIPE_ADV(adv),
    .TRAP_TAKEN(f[1]), .INT_RET(f[0]), .PROG_ADDR(pa),
    .PROG_ADDR_EXT(pa_ext), .EXE_RDATA(rdata), .RING1_ENABLE(r1e),
    .RING1_POINTER_SELECT(r1s), .RING2_ENABLE(r2e),
    .RING2_POINTER_SELECT(r2s), .VECTOR_PAGE_SELECT(vp),
    .ADDRESS_VISIBILITY(address_visibility), .EXT_ADDR(xa));
  // model: reads see state before this edge's update
  always @(posedge clk)
  begin
    exp_rd = !f[2] ? 0 : addr == 7'h1e ? ring : addr == 7'h07 ? mode : 0;
    if (f[1]) sh = mode;
    else if (f[0]) mode = sh;
    else if (f[3] && addr == 7'h07) mode = wdata & 16'hf880;
    if (f[3] && addr == 7'h1e) ring = int'(wdata[7:0]);
    // any mapped write or return restarts the two-slot hold
    if (f[0] || f[3] && (addr == 7'h1e || addr == 7'h07)) cnt = 2;
    else if (adv && cnt > 0 && --cnt == 0)
    begin
      cfg = ring;
      cfgm = mode;
    end
  end
  task automatic chk(string what, logic [15:0] got, int exp);
    n_checks++;
    if (got !== 16'(exp))
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, 16'(exp), got);
    end
  endtask
  always @(negedge clk)
    if (nrst)
    begin
      chk("read data", rdata, exp_rd);
      chk("ring outputs", {8'h00, r2e, r2s, r1e, r1s}, cfg);
      chk("mode outputs", {vp, 3'h0, address_visibility, 7'h00}, cfgm);
    end
  // f holds {write, read, trap, return}
  task automatic op(logic [3:0] fv, logic [6:0] a, logic [15:0] dv);
    f <= fv;
    addr <= a;
    wdata <= dv;
    @(negedge clk);
  endtask
  task automatic conclude();
    if (miscompares == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'he2ff1524));
    repeat (3) @(negedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk("vector page", {11'h0, vp}, 0);
    op(4'h4, 7'h1e, 16'h0);
    op(4'hc, 7'h07, 16'hffff);
    op(4'h4, 7'h07, 16'h0);
    repeat (4) op(4'h0, 7'h00, 16'h0);
    chk("mode outputs", {10'h0, vp, address_visibility}, 16'h3f);
    op(4'h2, 7'h00, 16'h0);
    op(4'hc, 7'h07, 16'h0800);
    op(4'h1, 7'h07, 16'h0);
    op(4'h4, 7'h07, 16'h0);
    slow <= 1'b1;
    repeat (400)
    begin
      d = 16'($urandom);
      d[6:4] = d[2:0] + 3'h1;
      k = $urandom % 4;
      ra = k == 3 ? 7'($urandom) : k == 2 ? 7'h07 : 7'h1e;
      op({ra == 7'h1e && k[0], 1'($urandom), 2'b00}, ra, d);
    end
    conclude();
  end
  initial
  begin
    #40000;
    miscompares++;
    conclude();
  end
endmodule
`default_nettype wire
